/* File: src/reset_class_register_init.sv */
// Register initialiser steered by reset class, with AXI4-Lite register access
`timescale 1ns/100ps
module reset_class_register_init
   import reset_init_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  por_bor_event,
   input  wire logic                  master_clear_reset_event,
   input  wire logic                  wdt_reset_event,
   input  wire logic                  reset_instr_event,
   input  wire logic                  stack_full_event,
   input  wire logic                  stack_underflow_event,
   input  wire logic                  wdt_wake_event,
   input  wire logic                  int_wake_event,
   input  wire logic                  int_wake_high_priority,
   input  wire logic                  osc_frees_first_port_input_hi,
   input  wire logic                  master_clear_pin_disabled,
   input  wire logic [7:0]            first_port_pins,
   input  wire logic [3:0]            fifth_port_pins,
   output logic [reset_init_pkg::PC_W-1:0] program_counter,
   output logic [4:0]                 stack_top_upper_byte,
   output logic [7:0]                 stack_top_high_byte,
   output logic [7:0]                 stack_top_low_byte,
   output logic [7:0]                 hardware_stack_pointer,
   output logic [7:0]                 first_port_latch,
   output logic [7:0]                 first_port_direction,
   output logic [3:0]                 fifth_port_latch,
   output reset_init_pkg::init_class_t init_class,
   output logic                       irq
);
   import reset_init_pkg::*;

   // ******************************************
   // Pin synchronisation
   // ******************************************
   logic [SYNC_W-1:0] sync_q;
   sync_stage #(.W(SYNC_W)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       ({osc_frees_first_port_input_hi, master_clear_pin_disabled, fifth_port_pins, first_port_pins}),
      .q       (sync_q)
   );
   logic       osc_ok;
   logic       master_clear_off;
   logic [7:0] pina_s;
   logic [3:0] pine_s;
   logic [7:0] first_port_input_mask;
   logic [3:0] fifth_port_input_mask;
   assign osc_ok           = sync_q[13];
   assign master_clear_off = sync_q[12];
   assign pine_s           = sync_q[11:8];
   assign pina_s           = sync_q[7:0];
   assign first_port_input_mask = {osc_ok, osc_ok, 6'h3f} & (FIRST_PORT_INPUT_LOW_MASK | {osc_ok, osc_ok, 6'h00});
   assign fifth_port_input_mask = {master_clear_off, 3'h7} & (FIFTH_PORT_INPUT_LOW_MASK | {master_clear_off, 3'h0});

   // ******************************************
   // State registers
   // ******************************************
   logic [PC_W-1:0]     pc_reg, pc_next, tos_reg, tos_next;
   logic [4:0]          sp_reg, sp_next;
   logic                full_reg, full_next, under_reg, under_next;
   logic [2:0]          ctrl_reg, ctrl_next;
   logic [7:0]          latch_a_reg, latch_a_next, dira_reg, dira_next, pina_reg, pina_next;
   logic [3:0]          late_reg, late_next, pine_reg, pine_next;
   logic [STATUS_W-1:0] status_reg, status_next, mask_reg, mask_next;
   init_class_t         class_reg, class_next;
   logic                irq_next;

   // ******************************************
   // AXI4-Lite slave state
   // ******************************************
   logic [7:0]  awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [3:0]  wstrb_reg, wstrb_next;
   logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
   logic        awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
   logic [1:0]  bresp_next, rresp_next;
   logic [31:0] rdata_next;
   logic        wr_fire;
   logic [31:0] wr_val;
   logic [31:0] rd_val;
   logic        rd_ok;
   logic [31:0] mrg;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;

   always_comb begin
      rd_ok  = 1'b1;
      rd_val = 32'h0;
      if (s_axi_araddr == OFS_CTRL) begin
         rd_val = {29'h0, ctrl_reg};
      end else if (s_axi_araddr == OFS_PC) begin
         rd_val = {11'h0, pc_reg};
      end else if (s_axi_araddr == OFS_STACKTOP) begin
         rd_val = {11'h0, tos_reg};
      end else if (s_axi_araddr == OFS_STACK_PTR) begin
         rd_val = {24'h0, full_reg, under_reg, 1'b0, sp_reg};
      end else if (s_axi_araddr == OFS_LATCH_A) begin
         rd_val = {24'h0, latch_a_reg};
      end else if (s_axi_araddr == OFS_DIRA) begin
         rd_val = {24'h0, dira_reg};
      end else if (s_axi_araddr == OFS_PINA) begin
         rd_val = {24'h0, pina_reg};
      end else if (s_axi_araddr == OFS_LATE) begin
         rd_val = {28'h0, late_reg};
      end else if (s_axi_araddr == OFS_PINE) begin
         rd_val = {28'h0, pine_reg};
      end else if (s_axi_araddr == OFS_CLASS) begin
         rd_val = {30'h0, class_reg};
      end else if (s_axi_araddr == OFS_STATUS) begin
         rd_val = {26'h0, status_reg};
      end else if (s_axi_araddr == OFS_MASK) begin
         rd_val = {26'h0, mask_reg};
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_comb begin
      awaddr_next  = awaddr_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      aw_have_next = aw_have_reg;
      w_have_next  = w_have_reg;
      bvalid_next  = s_axi_bvalid;
      bresp_next   = s_axi_bresp;
      rvalid_next  = s_axi_rvalid;
      rresp_next   = s_axi_rresp;
      rdata_next   = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_next  = s_axi_awaddr;
         aw_have_next = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_next  = s_axi_wdata;
         wstrb_next  = s_axi_wstrb;
         w_have_next = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (wr_fire) begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = (awaddr_reg <= OFS_MASK && awaddr_reg[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rdata_next  = rd_val;
         rresp_next  = rd_ok ? 2'b00 : 2'b10;
      end
      awready_next = !aw_have_next && !bvalid_next;
      wready_next  = !w_have_next && !bvalid_next;
      arready_next = !rvalid_next;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h0;
         wstrb_reg     <= 4'h0;
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= 2'b00;
         s_axi_rdata   <= 32'h0;
      end else begin
         awaddr_reg    <= awaddr_next;
         wdata_reg     <= wdata_next;
         wstrb_reg     <= wstrb_next;
         aw_have_reg   <= aw_have_next;
         w_have_reg    <= w_have_next;
         s_axi_awready <= awready_next;
         s_axi_wready  <= wready_next;
         s_axi_bvalid  <= bvalid_next;
         s_axi_bresp   <= bresp_next;
         s_axi_arready <= arready_next;
         s_axi_rvalid  <= rvalid_next;
         s_axi_rresp   <= rresp_next;
         s_axi_rdata   <= rdata_next;
      end
   end

   // ******************************************
   // Reset class and wake sequencing
   // ******************************************
   logic reset_any, high_hit, low_hit;
   logic [STATUS_W-1:0] st_set, st_clr;

   always_comb begin
      pc_next     = pc_reg;
      tos_next    = tos_reg;
      sp_next     = sp_reg;
      full_next   = full_reg;
      under_next  = under_reg;
      ctrl_next   = ctrl_reg;
      latch_a_next = latch_a_reg;
      mrg         = 32'h0;
      dira_next   = dira_reg;
      late_next   = late_reg;
      mask_next   = mask_reg;
      class_next  = class_reg;
      st_set      = '0;
      st_clr      = '0;
      wr_val      = merge(32'h0, wdata_reg, wstrb_reg);
      reset_any   = master_clear_reset_event || wdt_reset_event || reset_instr_event ||
                    ((stack_full_event || stack_underflow_event) && ctrl_reg[CTRL_FAULT_RST]);
      high_hit    = int_wake_high_priority && ctrl_reg[CTRL_HIGH_EN];
      low_hit     = !int_wake_high_priority && ctrl_reg[CTRL_LOW_EN];
      if (wr_fire) begin
         if (awaddr_reg == OFS_CTRL) begin
            mrg       = merge({29'h0, ctrl_reg}, wdata_reg, wstrb_reg);
            ctrl_next = mrg[2:0];
         end else if (awaddr_reg == OFS_PC) begin
            mrg     = merge({11'h0, pc_reg}, wdata_reg, wstrb_reg);
            pc_next = mrg[PC_W-1:0];
         end else if (awaddr_reg == OFS_LATCH_A) begin
            mrg          = merge({24'h0, latch_a_reg}, wdata_reg, wstrb_reg);
            latch_a_next = mrg[7:0];
         end else if (awaddr_reg == OFS_DIRA) begin
            mrg       = merge({24'h0, dira_reg}, wdata_reg, wstrb_reg);
            dira_next = mrg[7:0];
         end else if (awaddr_reg == OFS_LATE) begin
            mrg       = merge({28'h0, late_reg}, wdata_reg, wstrb_reg);
            late_next = mrg[3:0];
         end else if (awaddr_reg == OFS_STATUS) begin
            st_clr = wr_val[STATUS_W-1:0];
         end else if (awaddr_reg == OFS_MASK) begin
            mrg       = merge({26'h0, mask_reg}, wdata_reg, wstrb_reg);
            mask_next = mrg[STATUS_W-1:0];
         end
      end
      if (por_bor_event) begin
         class_next = CLASS_POWER;
         pc_next    = PC_ZERO;
         tos_next   = PC_ZERO;
         sp_next    = 5'h00;
         full_next  = 1'b0;
         under_next = 1'b0;
         ctrl_next  = 3'h0;
         latch_a_next = 8'h00;
         dira_next  = DIR_RESET;
         late_next  = 4'h0;
         st_set[ST_POWER] = 1'b1;
      end else if (reset_any) begin
         class_next = CLASS_RESET;
         pc_next    = PC_ZERO;
         tos_next   = PC_ZERO;
         sp_next    = 5'h00;
         ctrl_next[CTRL_HIGH_EN] = 1'b0;
         ctrl_next[CTRL_LOW_EN]  = 1'b0;
         if (stack_full_event && ctrl_reg[CTRL_FAULT_RST]) begin
            full_next = 1'b1;
         end
         if (stack_underflow_event && ctrl_reg[CTRL_FAULT_RST]) begin
            under_next = 1'b1;
         end
         st_set[ST_RESET] = 1'b1;
      end else if (stack_underflow_event) begin
         under_next = 1'b1;
         pc_next    = PC_ZERO;
         st_set[ST_UNDERFLOW] = 1'b1;
      end else if (int_wake_event) begin
         class_next = CLASS_WAKE;
         st_set[ST_WAKE_INT] = 1'b1;
         if (high_hit || low_hit) begin
            tos_next = pc_reg;
            sp_next  = sp_reg + 5'h01;
            pc_next  = high_hit ? VEC_HIGH : VEC_LOW;
         end else begin
            pc_next = pc_reg + PC_STEP;
         end
      end else if (wdt_wake_event) begin
         class_next = CLASS_WAKE;
         pc_next    = pc_reg + PC_STEP;
         st_set[ST_WAKE_WDT] = 1'b1;
      end
      if (stack_full_event && !ctrl_reg[CTRL_FAULT_RST] && !por_bor_event) begin
         full_next = 1'b1;
         st_set[ST_FULL] = 1'b1;
      end
      latch_a_next = latch_a_next & first_port_input_mask;
      dira_next   = dira_next & first_port_input_mask;
      pina_next   = pina_s & first_port_input_mask;
      late_next   = late_next & fifth_port_input_mask;
      pine_next   = pine_s & fifth_port_input_mask;
      status_next = (status_reg & ~st_clr) | st_set;
      irq_next    = |(status_next & mask_next);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_reg     <= PC_ZERO;
         tos_reg    <= PC_ZERO;
         sp_reg     <= 5'h00;
         full_reg   <= 1'b0;
         under_reg  <= 1'b0;
         ctrl_reg   <= 3'h0;
         latch_a_reg <= 8'h00;
         dira_reg   <= 8'h00;
         pina_reg   <= 8'h00;
         late_reg   <= 4'h0;
         pine_reg   <= 4'h0;
         status_reg <= '0;
         mask_reg   <= '0;
         class_reg  <= CLASS_NONE;
         irq        <= 1'b0;
      end else begin
         pc_reg     <= pc_next;
         tos_reg    <= tos_next;
         sp_reg     <= sp_next;
         full_reg   <= full_next;
         under_reg  <= under_next;
         ctrl_reg   <= ctrl_next;
         latch_a_reg <= latch_a_next;
         dira_reg   <= dira_next;
         pina_reg   <= pina_next;
         late_reg   <= late_next;
         pine_reg   <= pine_next;
         status_reg <= status_next;
         mask_reg   <= mask_next;
         class_reg  <= class_next;
         irq        <= irq_next;
      end
   end

   assign program_counter        = pc_reg;
   assign stack_top_upper_byte   = tos_reg[20:16];
   assign stack_top_high_byte    = tos_reg[15:8];
   assign stack_top_low_byte     = tos_reg[7:0];
   assign hardware_stack_pointer = {full_reg, under_reg, 1'b0, sp_reg};
   assign first_port_latch       = latch_a_reg;
   assign first_port_direction   = dira_reg;
   assign fifth_port_latch       = late_reg;
   assign init_class             = class_reg;

   // ******************************************
   // Assertions
   // ******************************************
   a_power_class: assert property (@(posedge aclk) disable iff (!aresetn)
      por_bor_event |=> (class_reg == CLASS_POWER && pc_reg == PC_ZERO && sp_reg == 5'h00 && !under_reg))
      else $error("power class not loaded");
   a_reset_keeps_flags: assert property (@(posedge aclk) disable iff (!aresetn)
      (!por_bor_event && master_clear_reset_event && !stack_full_event && !stack_underflow_event)
      |=> (class_reg == CLASS_RESET && full_reg == $past(full_reg) && under_reg == $past(under_reg)))
      else $error("reset class disturbed stack flags");
   a_wake_vector: assert property (@(posedge aclk) disable iff (!aresetn)
      (!por_bor_event && !reset_any && !stack_underflow_event && int_wake_event && high_hit)
      |=> pc_reg == VEC_HIGH)
      else $error("wake vector wrong");
   a_wake_push: assert property (@(posedge aclk) disable iff (!aresetn)
      (!por_bor_event && !reset_any && !stack_underflow_event && int_wake_event && (high_hit || low_hit))
      |=> (tos_reg == $past(pc_reg) && sp_reg == $past(sp_reg) + 5'h01))
      else $error("wake push wrong");
   a_wake_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      (!por_bor_event && !reset_any && !stack_underflow_event && wdt_wake_event && !int_wake_event)
      |=> status_reg[ST_WAKE_WDT] && status_reg[ST_WAKE_INT] == $past(status_reg[ST_WAKE_INT]))
      else $error("wake flag wrong");
   a_first_port_input_hidden: assert property (@(posedge aclk) disable iff (!aresetn)
      !osc_ok [*2] |-> (latch_a_reg[7:6] == 2'b00 && dira_reg[7:6] == 2'b00 && pina_reg[7:6] == 2'b00))
      else $error("port a high bits visible");
   a_fifth_port_input_hidden: assert property (@(posedge aclk) disable iff (!aresetn)
      !master_clear_off [*2] |-> (late_reg[3] == 1'b0 && pine_reg[3] == 1'b0))
      else $error("port e bit 3 visible");
   a_underflow_err: assert property (@(posedge aclk) disable iff (!aresetn)
      (!por_bor_event && !reset_any && stack_underflow_event)
      |=> (under_reg && pc_reg == PC_ZERO && class_reg == $past(class_reg)))
      else $error("underflow error wrong");
endmodule // reset_class_register_init

/* File: src/reset_init_pkg.sv */
// Constants, offsets and types for the reset class register initialiser
package reset_init_pkg;
   // ******************************************
   // Register offsets (byte addresses)
   // ******************************************
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_PC       = 8'h04;
   localparam logic [7:0] OFS_STACKTOP = 8'h08;
   localparam logic [7:0] OFS_STACK_PTR = 8'h0c;
   localparam logic [7:0] OFS_LATCH_A  = 8'h10;
   localparam logic [7:0] OFS_DIRA     = 8'h14;
   localparam logic [7:0] OFS_PINA     = 8'h18;
   localparam logic [7:0] OFS_LATE     = 8'h1c;
   localparam logic [7:0] OFS_PINE     = 8'h20;
   localparam logic [7:0] OFS_CLASS    = 8'h24;
   localparam logic [7:0] OFS_STATUS   = 8'h28;
   localparam logic [7:0] OFS_MASK     = 8'h2c;
   // ******************************************
   // Field positions
   // ******************************************
   localparam int CTRL_HIGH_EN   = 0;
   localparam int CTRL_LOW_EN    = 1;
   localparam int CTRL_FAULT_RST = 2;
   localparam int SP_FULL        = 7;
   localparam int SP_UNDER       = 6;
   localparam int ST_POWER       = 0;
   localparam int ST_RESET       = 1;
   localparam int ST_WAKE_WDT    = 2;
   localparam int ST_WAKE_INT    = 3;
   localparam int ST_UNDERFLOW   = 4;
   localparam int ST_FULL        = 5;
   localparam int STATUS_W       = 6;
   localparam int PC_W           = 21;
   // ******************************************
   // Values after reset and fixed addresses
   // ******************************************
   localparam logic [PC_W-1:0] PC_ZERO  = 21'h000000;
   localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
   localparam logic [PC_W-1:0] VEC_LOW  = 21'h000018;
   localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
   localparam logic [7:0]      DIR_RESET = 8'hff;
   localparam logic [7:0]      FIRST_PORT_INPUT_LOW_MASK = 8'h3f;
   localparam logic [3:0]      FIFTH_PORT_INPUT_LOW_MASK = 4'h7;
   localparam int              SYNC_W = 14;
   typedef enum logic [1:0] {CLASS_NONE, CLASS_POWER, CLASS_RESET, CLASS_WAKE} init_class_t;
endpackage

/* File: src/sync_stage.sv */
// Two flip-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module sync_stage #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule // sync_stage

/* File: dv/test_reset_class_register_init.sv */
// Self-checking testbench for the reset class register initialiser
`timescale 1ns/100ps
module test_reset_class_register_init;
   import reset_init_pkg::*;
   // ************************************
   // Signals
   // ************************************
   logic            aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic            arvalid, arready, rvalid, rready, hp, osc, mcd, irq;
   logic [7:0]      awaddr, araddr, ev, pa, th, tl, sp, lat_a, dir_a;
   logic [31:0]     wdata, rdata, rd_data;
   logic [1:0]      bresp, rresp, wr_resp, rd_resp;
   logic [3:0]      pe, lat_e;
   logic [4:0]      tu;
   logic [PC_W-1:0] pc;
   init_class_t     cls;
   int              errors, n_checks;

   reset_class_register_init DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .por_bor_event(ev[0]), .master_clear_reset_event(ev[1]), .wdt_reset_event(ev[2]),
      .reset_instr_event(ev[3]), .stack_full_event(ev[4]), .stack_underflow_event(ev[5]),
      .wdt_wake_event(ev[6]), .int_wake_event(ev[7]), .int_wake_high_priority(hp),
      .osc_frees_first_port_input_hi(osc), .master_clear_pin_disabled(mcd), .first_port_pins(pa),
      .fifth_port_pins(pe), .program_counter(pc), .stack_top_upper_byte(tu), .stack_top_high_byte(th),
      .stack_top_low_byte(tl), .hardware_stack_pointer(sp), .first_port_latch(lat_a),
      .first_port_direction(dir_a), .fifth_port_latch(lat_e), .init_class(cls), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // ************************************
   // Tasks
   // ************************************
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         wr_resp = bresp;
         @(posedge aclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end while (!b);
      bready <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic t, r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         t = arvalid & arready;
         r = rvalid;
         rd_data = rdata;
         rd_resp = rresp;
         @(posedge aclk);
         if (t) arvalid <= 1'b0;
      end while (!r);
      rready <= 1'b0;
      chk(nm, rd_data, e);
   endtask
   // One-cycle event pulse on the numbered event input
   task automatic pulse(input int i);
      @(posedge aclk);
      ev <= 8'h01 << i;
      @(posedge aclk);
      ev <= 8'h00;
      idle(2);
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      finish_test;
   end
   // ************************************
   // Tests
   // ************************************
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, hp, osc, mcd} = 9'h000;
      {awaddr, araddr, wdata, ev} = 56'h0;
      pa = 8'hc5;
      pe = 4'hf;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      idle(2);
      chk("direction", dir_a, 8'h00);
      pulse(0);
      chk("class", cls, CLASS_POWER);
      chk("direction", dir_a, 8'h3f);
      rc(8'h28, 32'h1, "status");
      wr(8'h2c, 32'h3f);
      idle(2);
      chk("irq", irq, 1'b1);
      wr(8'h28, 32'h1);
      idle(2);
      chk("irq", irq, 1'b0);
      @(posedge aclk) osc <= 1'b1;
      idle(5);
      wr(8'h10, 32'hff);
      chk("latch a", lat_a, 8'hff);
      rc(8'h18, 32'hc5, "pins a");
      @(posedge aclk) osc <= 1'b0;
      idle(5);
      chk("latch a", lat_a, 8'h3f);
      rc(8'h18, 32'h05, "pins a");
      wr(8'h1c, 32'hf);
      chk("latch e", lat_e, 4'h7);
      rc(8'h20, 32'h7, "pins e");
      @(posedge aclk) mcd <= 1'b1;
      idle(5);
      wr(8'h1c, 32'hf);
      chk("latch e", lat_e, 4'hf);
      rc(8'h20, 32'hf, "pins e");
      wr(8'h00, 32'h1);
      wr(8'h04, 32'h1234);
      @(posedge aclk) hp <= 1'b1;
      pulse(7);
      chk("pc", pc, 21'h8);
      chk("stack top", {tu, th, tl}, 21'h1234);
      chk("pointer", sp, 8'h01);
      chk("class", cls, CLASS_WAKE);
      wr(8'h00, 32'h2);
      @(posedge aclk) hp <= 1'b0;
      pulse(7);
      chk("pc", pc, 21'h18);
      chk("stack top", {tu, th, tl}, 21'h8);
      chk("pointer", sp, 8'h02);
      @(posedge aclk) hp <= 1'b1;
      pulse(7);
      chk("pc", pc, 21'h1a);
      rc(8'h28, 32'h8, "status");
      pulse(6);
      chk("pc", pc, 21'h1c);
      rc(8'h28, 32'hc, "status");
      wr(8'h00, 32'h7);
      for (int i = 1; i < 5; i++) begin
         wr(8'h04, 32'h40);
         pulse(i);
         chk("pc", pc, 21'h0);
         chk("class", cls, CLASS_RESET);
      end
      chk("pointer", sp, 8'h80);
      chk("stack top", {tu, th, tl}, 21'h0);
      rc(8'h00, 32'h4, "control");
      wr(8'h00, 32'h0);
      wr(8'h28, 32'h3f);
      wr(8'h04, 32'h50);
      pulse(6);
      chk("pc", pc, 21'h52);
      pulse(5);
      chk("pc", pc, 21'h0);
      chk("pointer", sp, 8'hc0);
      chk("class", cls, CLASS_WAKE);
      rc(8'h28, 32'h14, "status");
      chk("irq", irq, 1'b1);
      rc(8'h30, 32'h0, "unmapped");
      chk("rresp", rd_resp, 2'b10);
      wr(8'h3c, 32'h1);
      chk("bresp", wr_resp, 2'b10);
      finish_test;
   end
endmodule // test_reset_class_register_init
